// file: logic/brc_ctrl.sv
// block reset and clock gating controller with its register file
`timescale 1ns/1ps
// Notes on behaviour
// R1: disabled block is reset and clock-gated, block 0 reset only
// R2: dma, interrupt, flow, congestion, control regs: global only
// R3: enables 1..8 reset initiator, target, message, port blocks
// R4: global enable resets all but config interface
// R5: config bus keeps working during global reset
// R6: block 0 resets only registers above 01fch
// R7: global enable is bit 0 at 0030h
// R8: global enable ored with reset, fanned to blocks
// R9: global reset touches only this peripheral
// R10: software reset is abrupt, returns initial state
// R11: after reset both ends retrain the link
// R12: no data or non-status symbols before initialisation
// R13: serdes reset independent of all enables
// R14: serdes channel enable is bit 0 of config
// R15: pll enable off stops serdes clocks
// R16: software powers pll down only for full shutdown
// R17: disabled transmitter holds both outputs high
// R18: serdes reference domain uses asynchronous reset
// R19: global enable clear holds peripheral in reset
// R20: status bit 0 global, bits 1..9 blocks
// R21: status changes after action took effect
// R22: gating glitch-free, reset wraps clock stop
module brc_ctrl
    import brc_pkg::*;
#(
    parameter int NUM_LANE = BRC_NUM_LANE
)
(
    input  wire logic                sys_clk,            // 125 mhz system clock
    input  wire logic                sys_rst,            // bus reset, async, high
    input  wire brc_cfg_s            cfg,                // config bus request
    output logic [31:0]              cfg_rdata,          // read data, with ack
    output logic                     cfg_ack,            // one-cycle answer
    output logic                     common_rst,         // dma/ihu/flow/ccu reset
    output wire logic                common_clk,         // gated common clock
    output logic [BRC_NUM_BLK-1:0]   blk_rst,            // per-block reset
    output wire logic [BRC_NUM_BLK-1:0] blk_clk,         // per-block gated clock
    output logic                     serdes_rst,         // serdes macro reset
    output logic                     serdes_pll_enable,  // pll enable to serdes
    output logic [NUM_LANE-1:0]      serdes_tx_enable,   // per-lane tx enable
    output logic [NUM_LANE-1:0]      serdes_rx_enable,   // per-lane rx enable
    input  wire logic [NUM_LANE-1:0] link_init_done,     // port initialised, async
    input  wire logic [NUM_LANE-1:0] tx_serial,          // lane serial data
    output logic [NUM_LANE-1:0]      port_retrain,       // port must retrain
    output logic [NUM_LANE-1:0]      tx_data_allow,      // data/non-status allowed
    output logic [NUM_LANE-1:0]      tx_positive_output, // lane p output
    output logic [NUM_LANE-1:0]      tx_negative_output  // lane n output
);
    if (NUM_LANE < 1 || NUM_LANE > 4) begin : g_bad_lane
        $error("brc_ctrl: NUM_LANE must be 1..4");
    end

    // ------------------------------------------------------------------
    // control registers (bus reset only; scratch also cleared by block 0)
    // ------------------------------------------------------------------
    logic                   glb_en_ff;
    logic [BRC_NUM_BLK-1:0] blk_en_ff;
    logic                   pll_en_ff;
    logic [NUM_LANE-1:0]    tx_cfg_ff;
    logic [NUM_LANE-1:0]    rx_cfg_ff;
    logic [31:0]            scratch_ff;
    logic                   common_on;
    logic                   common_clk_en;
    logic [BRC_NUM_BLK-1:0] blk_on;
    logic [BRC_NUM_BLK-1:0] blk_clk_en;
    logic                   wr_hit;
    logic [11:0]            blk_ofs;
    logic [3:0]             blk_idx;
    logic                   blk_reg;

    assign wr_hit  = cfg.req && cfg.wr;
    assign blk_ofs = cfg.addr - BRC_OFS_BLK_BASE;
    assign blk_idx = blk_ofs[6:3];
    assign blk_reg = cfg.addr >= BRC_OFS_BLK_BASE && cfg.addr <= BRC_OFS_BLK_LAST
                     && cfg.addr[1:0] == 2'b00;

    // these sit inside 0000h-01fch, so no enable can clear them
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            glb_en_ff <= BRC_GLB_EN_RST;
            blk_en_ff <= {BRC_NUM_BLK{BRC_BLK_EN_RST}};
        end else if (wr_hit) begin
            if (cfg.addr == BRC_OFS_GLB_EN) begin
                glb_en_ff <= cfg.wdata[BRC_EN_BIT];                      // R7
            end
            if (blk_reg && !blk_ofs[2]) begin
                blk_en_ff[blk_idx] <= cfg.wdata[BRC_EN_BIT];             // R2
            end
        end
    end

    // serdes controls ignore every enable
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pll_en_ff <= BRC_PLL_EN_RST;
            tx_cfg_ff <= {NUM_LANE{BRC_CH_EN_RST}};
            rx_cfg_ff <= {NUM_LANE{BRC_CH_EN_RST}};
        end else if (wr_hit) begin
            if (cfg.addr == BRC_OFS_SERDES_GLB) begin
                pll_en_ff <= cfg.wdata[BRC_PLL_EN_BIT];                  // R13
            end
            for (int i = 0; i < NUM_LANE; i++) begin
                if (cfg.addr == BRC_OFS_TX_CFG + 12'(4 * i)) begin
                    tx_cfg_ff[i] <= cfg.wdata[BRC_CH_EN_BIT];            // R14
                end
                if (cfg.addr == BRC_OFS_RX_CFG + 12'(4 * i)) begin
                    rx_cfg_ff[i] <= cfg.wdata[BRC_CH_EN_BIT];            // R14
                end
            end
        end
    end

    // general register above the reset-control range, cleared by block 0
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            scratch_ff <= 32'h0000_0000;
        end else if (blk_rst[0]) begin
            scratch_ff <= 32'h0000_0000;                                 // R4 R6
        end else if (wr_hit && cfg.addr == BRC_OFS_SCRATCH) begin
            scratch_ff <= cfg.wdata;
        end
    end

    // ------------------------------------------------------------------
    // config bus read port: only bus reset touches it
    // ------------------------------------------------------------------
    logic [31:0] rd_data;

    always_comb begin
        rd_data = 32'h0000_0000;
        if (cfg.addr == BRC_OFS_GLB_EN) begin
            rd_data[BRC_EN_BIT] = glb_en_ff;
        end else if (cfg.addr == BRC_OFS_GLB_STAT) begin
            rd_data[BRC_NUM_BLK:0] = {blk_on, common_on};                // R20
        end else if (blk_reg) begin
            rd_data[BRC_EN_BIT] = blk_ofs[2] ? blk_on[blk_idx] : blk_en_ff[blk_idx];
        end else if (cfg.addr == BRC_OFS_SERDES_GLB) begin
            rd_data[BRC_PLL_EN_BIT] = pll_en_ff;
        end else if (cfg.addr == BRC_OFS_SCRATCH) begin
            rd_data = scratch_ff;
        end else begin
            for (int i = 0; i < NUM_LANE; i++) begin
                if (cfg.addr == BRC_OFS_TX_CFG + 12'(4 * i)) begin
                    rd_data[BRC_CH_EN_BIT] = tx_cfg_ff[i];
                end
                if (cfg.addr == BRC_OFS_RX_CFG + 12'(4 * i)) begin
                    rd_data[BRC_CH_EN_BIT] = rx_cfg_ff[i];
                end
            end
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cfg_ack   <= 1'b0;
            cfg_rdata <= 32'h0000_0000;
        end else begin
            cfg_ack   <= cfg.req;                                        // R5
            cfg_rdata <= (cfg.req && !cfg.wr) ? rd_data : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------------
    // reset hierarchy: global enable anded into every block request
    // ------------------------------------------------------------------
    // outputs stay inside the peripheral; no chip-level reset is driven
    brc_blk_seq #(.GATE(1'b1), .SETTLE(BRC_SETTLE_CYC)) u_common_seq (
        .sys_clk  (sys_clk),
        .sys_rst  (sys_rst),
        .req_on   (glb_en_ff),                                           // R8 R9 R19
        .blk_rst  (common_rst),
        .clk_en   (common_clk_en),
        .state_on (common_on)
    );

    brc_clk_gate u_common_gate (
        .sys_clk   (sys_clk),
        .sys_rst   (sys_rst),
        .clk_en    (common_clk_en),
        .gated_clk (common_clk)
    );

    generate
        for (genvar b = 0; b < BRC_NUM_BLK; b++) begin : g_blk
            brc_blk_seq #(.GATE(b != 0), .SETTLE(BRC_SETTLE_CYC)) u_seq (
                .sys_clk  (sys_clk),
                .sys_rst  (sys_rst),
                .req_on   (glb_en_ff && blk_en_ff[b]),                   // R3 R4 R8
                .blk_rst  (blk_rst[b]),
                .clk_en   (blk_clk_en[b]),
                .state_on (blk_on[b])
            );
            brc_clk_gate u_gate (
                .sys_clk   (sys_clk),
                .sys_rst   (sys_rst),
                .clk_en    (blk_clk_en[b]),                              // R1
                .gated_clk (blk_clk[b])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // serdes controls
    // ------------------------------------------------------------------
    // the reference clock domain behind these takes its reset without a clock
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            serdes_rst        <= 1'b1;                                   // R18
            serdes_pll_enable <= 1'b0;
            serdes_tx_enable  <= '0;
            serdes_rx_enable  <= '0;
        end else begin
            serdes_rst        <= 1'b0;                                   // R13
            serdes_pll_enable <= pll_en_ff;                              // R15
            serdes_tx_enable  <= tx_cfg_ff & {NUM_LANE{pll_en_ff}};      // R15
            serdes_rx_enable  <= rx_cfg_ff & {NUM_LANE{pll_en_ff}};
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tx_positive_output <= {NUM_LANE{1'b1}};
            tx_negative_output <= {NUM_LANE{1'b1}};
        end else begin
            tx_positive_output <= ~serdes_tx_enable | tx_serial;         // R17
            tx_negative_output <= ~serdes_tx_enable | ~tx_serial;        // R17
        end
    end

    // ------------------------------------------------------------------
    // link re-establishment per port
    // ------------------------------------------------------------------
    logic [NUM_LANE-1:0] init_s1_ff;
    logic [NUM_LANE-1:0] init_s2_ff;
    logic [NUM_LANE-1:0] init_s3_ff;
    logic [NUM_LANE-1:0] init_ok_ff;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            init_s1_ff <= '0;
            init_s2_ff <= '0;
            init_s3_ff <= '0;
            init_ok_ff <= '0;
        end else begin
            init_s1_ff <= link_init_done;
            init_s2_ff <= init_s1_ff;
            init_s3_ff <= init_s2_ff;
            for (int i = 0; i < NUM_LANE; i++) begin
                if (init_s2_ff[i] == init_s3_ff[i]) begin
                    init_ok_ff[i] <= init_s3_ff[i];
                end
            end
        end
    end

    // a stale "done" from before the reset is not trusted: the partner
    // must drop and raise it again, which proves a fresh training
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            port_retrain  <= {NUM_LANE{1'b1}};
            tx_data_allow <= '0;
        end else begin
            for (int i = 0; i < NUM_LANE; i++) begin
                if (blk_rst[BRC_PORT_BLK + i] || common_rst) begin
                    port_retrain[i] <= 1'b1;                             // R11
                end else if (!init_s2_ff[i] && !init_s3_ff[i]) begin
                    port_retrain[i] <= 1'b0;
                end
                tx_data_allow[i] <= !port_retrain[i] && init_ok_ff[i]    // R12
                                    && !blk_rst[BRC_PORT_BLK + i] && !common_rst;
            end
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    a_gate_after_rst:  assert property ($fell(blk_clk_en[1]) |-> blk_rst[1]) // R22
        else $error("block clock stopped without reset");
    a_stat_after_run:  assert property ($rose(blk_on[1]) |-> blk_clk_en[1] && !blk_rst[1]) // R21
        else $error("status rose before block ran");
    a_glb_off_reset:   assert property (!glb_en_ff |-> ##[1:3] (common_rst && &blk_rst)) // R19
        else $error("global disable did not reset blocks");
    a_blk0_no_gate:    assert property (blk_clk_en[0]) // R1
        else $error("register block clock was gated");
    a_ctl_kept:        assert property (!wr_hit |=> $stable(blk_en_ff) && $stable(glb_en_ff)) // R2
        else $error("control register changed without write");
    a_cfg_alive:       assert property (cfg.req |=> cfg_ack) // R5
        else $error("config bus not answered");
    a_scratch_clear:   assert property (blk_rst[0] |=> scratch_ff == 32'h0000_0000) // R6
        else $error("register not cleared by block 0 reset");
    a_no_tx_training:  assert property (port_retrain[0] |=> !tx_data_allow[0]) // R12
        else $error("data allowed during training");
    a_tx_high_off:     assert property (!serdes_tx_enable[0] |=> tx_positive_output[0]
                                        && tx_negative_output[0]) // R17
        else $error("disabled transmitter not held high");
    a_pll_stops_tx:    assert property (!pll_en_ff |=> serdes_tx_enable == '0) // R15
        else $error("tx enabled with pll off");
    a_serdes_indep:    assert property (!glb_en_ff |=> !serdes_rst) // R13
        else $error("serdes reset by global enable");
endmodule

// file: logic/brc_pkg.sv
// constants, types and register map of the block reset and clock gating controller
package brc_pkg;

    // ------------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------------
    localparam int BRC_NUM_BLK  = 9;
    localparam int BRC_NUM_LANE = 4;
    localparam int BRC_PORT_BLK = 5;          // block index of port 0 datapath

    // ------------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [11:0] BRC_OFS_GLB_EN     = 12'h030;
    localparam logic [11:0] BRC_OFS_GLB_STAT   = 12'h034;
    localparam logic [11:0] BRC_OFS_BLK_BASE   = 12'h038;
    localparam logic [11:0] BRC_OFS_BLK_LAST   = 12'h07c;
    localparam logic [11:0] BRC_OFS_SERDES_GLB = 12'h100;
    localparam logic [11:0] BRC_OFS_TX_CFG     = 12'h104;
    localparam logic [11:0] BRC_OFS_RX_CFG     = 12'h114;
    localparam logic [11:0] BRC_OFS_CTL_END    = 12'h1fc;
    localparam logic [11:0] BRC_OFS_SCRATCH    = 12'h200;

    // ------------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------------
    localparam int   BRC_EN_BIT     = 0;
    localparam int   BRC_PLL_EN_BIT = 0;
    localparam int   BRC_CH_EN_BIT  = 0;
    localparam logic BRC_GLB_EN_RST = 1'b1;
    localparam logic BRC_BLK_EN_RST = 1'b1;
    localparam logic BRC_PLL_EN_RST = 1'b0;
    localparam logic BRC_CH_EN_RST  = 1'b0;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int BRC_CLK_PERIOD_PS = 8000;
    localparam int BRC_SETTLE_NS     = 16;     // clock runs this long before reset release
    localparam int BRC_SETTLE_CYC    =
        (BRC_SETTLE_NS * 1000 + BRC_CLK_PERIOD_PS - 1) / BRC_CLK_PERIOD_PS;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic        req;
        logic        wr;
        logic [11:0] addr;
        logic [31:0] wdata;
    } brc_cfg_s;

    typedef enum logic [1:0] {
        BRC_SEQ_OFF    = 2'b00,
        BRC_SEQ_CLK_ON = 2'b01,
        BRC_SEQ_RUN    = 2'b11,
        BRC_SEQ_RST_ON = 2'b10
    } brc_seq_e;

endpackage

// file: logic/brc_clk_gate.sv
// glitch-free clock gate for one logical block
`timescale 1ns/1ps
module brc_clk_gate
    import brc_pkg::*;
(
    input  wire logic sys_clk,   // free-running clock
    input  wire logic sys_rst,   // async reset, high
    input  wire logic clk_en,    // enable, changes after rising edge
    output wire logic gated_clk  // gated block clock
);
    // enable is taken on the falling edge so it only changes while the
    // clock is low; the clock then stops and restarts on whole periods
    logic en_lo_ff;

    always_ff @(negedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            en_lo_ff <= 1'b0;
        end else begin
            en_lo_ff <= clk_en;   // R22
        end
    end

    assign gated_clk = sys_clk & en_lo_ff;
endmodule

// file: logic/brc_blk_seq.sv
// reset and clock-enable sequencer for one logical block
`timescale 1ns/1ps
module brc_blk_seq
    import brc_pkg::*;
#(
    parameter bit GATE   = 1'b1,           // 0: reset only, clock never gated
    parameter int SETTLE = BRC_SETTLE_CYC  // cycles of running clock before release
)
(
    input  wire logic sys_clk,   // system clock
    input  wire logic sys_rst,   // async reset, high
    input  wire logic req_on,    // block requested enabled
    output logic      blk_rst,   // block reset, high
    output logic      clk_en,    // clock enable for the gate
    output logic      state_on   // enabled with clock running
);
    // the settle counter is four bits wide and the wait lasts at least one cycle
    if (SETTLE < 1 || SETTLE > 15) begin : g_bad_settle
        $error("brc_blk_seq: SETTLE out of range");
    end

    brc_seq_e   state_ff;
    logic [3:0] cnt_ff;

    // no handshake with the block: reset is applied whatever it is doing
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_ff <= BRC_SEQ_OFF;
            blk_rst  <= 1'b1;
            clk_en   <= !GATE;
            state_on <= 1'b0;
            cnt_ff   <= 4'h0;
        end else begin
            unique case (state_ff)
                BRC_SEQ_OFF: begin
                    if (req_on) begin
                        state_ff <= BRC_SEQ_CLK_ON;
                        clk_en   <= 1'b1;
                        cnt_ff   <= 4'h0;
                    end
                end
                BRC_SEQ_CLK_ON: begin
                    if (!req_on) begin
                        state_ff <= BRC_SEQ_RST_ON;   // R10
                    end else if (cnt_ff == 4'(SETTLE - 1)) begin
                        state_ff <= BRC_SEQ_RUN;
                        blk_rst  <= 1'b0;             // R22
                        state_on <= 1'b1;             // R21
                    end else begin
                        cnt_ff <= cnt_ff + 4'h1;
                    end
                end
                BRC_SEQ_RUN: begin
                    if (!req_on) begin
                        state_ff <= BRC_SEQ_RST_ON;
                        blk_rst  <= 1'b1;             // R10
                    end
                end
                BRC_SEQ_RST_ON: begin
                    state_ff <= BRC_SEQ_OFF;
                    clk_en   <= !GATE;                // R1 R22
                    state_on <= 1'b0;                 // R21
                end
            endcase
        end
    end
endmodule

// file: tb/brc_ctrl_tb.sv
// self-checking testbench of the block reset and clock gating controller
`timescale 1ns/1ps
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin num_errors++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module block_reset_clock_gating_tb_top;
    import brc_pkg::*;
    // ------------------------------------------------------------------
    // signals
    // ------------------------------------------------------------------
    logic                   sys_clk = 1'b0;
    logic                   sys_rst = 1'b1;
    brc_cfg_s               cfg = '0;
    logic [31:0]            cfg_rdata;
    logic                   cfg_ack, common_rst, common_clk, serdes_rst, serdes_pll_enable;
    logic [BRC_NUM_BLK-1:0] blk_rst, blk_clk;
    logic [3:0]             serdes_tx_enable, serdes_rx_enable, port_retrain, tx_data_allow;
    logic [3:0]             tx_positive_output, tx_negative_output;
    logic [3:0]             link_init_done = 4'hf;
    logic [3:0]             tx_serial = 4'h0;
    logic [32:0]            exp_q[$];
    logic [32:0]            note;
    logic [15:0]            seed = 16'h0047;
    int                     num_errors = 0;
    int                     samples_checked = 0;

    always #4 sys_clk = ~sys_clk;

    brc_ctrl DUT (.sys_clk(sys_clk), .sys_rst(sys_rst), .cfg(cfg), .cfg_rdata(cfg_rdata),
        .cfg_ack(cfg_ack), .common_rst(common_rst), .common_clk(common_clk),
        .blk_rst(blk_rst), .blk_clk(blk_clk), .serdes_rst(serdes_rst),
        .serdes_pll_enable(serdes_pll_enable), .serdes_tx_enable(serdes_tx_enable),
        .serdes_rx_enable(serdes_rx_enable), .link_init_done(link_init_done),
        .tx_serial(tx_serial), .port_retrain(port_retrain), .tx_data_allow(tx_data_allow),
        .tx_positive_output(tx_positive_output), .tx_negative_output(tx_negative_output));

    // ------------------------------------------------------------------
    // drivers and scoreboard
    // ------------------------------------------------------------------
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // the expected note goes in before the request so the ack always finds it
    task automatic op(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [32:0] e);
        exp_q.push_back(e);
        cfg <= '{req: 1'b1, wr: w, addr: a, wdata: d};
        @(posedge sys_clk);
        cfg.req <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic wr32(input logic [11:0] a, input logic [31:0] d);
        op(1'b1, a, d, 33'h0);
    endtask
    task automatic rd32(input logic [11:0] a, input logic [31:0] e);
        op(1'b0, a, 32'h0, {1'b1, e});
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // gated clocks are looked at mid high phase, away from both edges
    task automatic clk_chk(input logic [9:0] e);
        #2;
        `CHK({common_clk, blk_clk}, e)
        @(posedge sys_clk);
    endtask

    always @(posedge sys_clk) begin
        if (cfg_ack === 1'b1) begin
            note = (exp_q.size() > 0) ? exp_q.pop_front() : {1'b1, 32'hdeaddead};
            if (note[32]) `CHK(cfg_rdata, note[31:0])
        end
    end

    task automatic close_out();
        if (exp_q.size() != 0) num_errors++;
        $display("checked %0d, errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        #(8 * 20000);
        num_errors++;
        close_out();
    end

    // ------------------------------------------------------------------
    // tests
    // ------------------------------------------------------------------
    initial begin
        cyc(12);
        sys_rst <= 1'b0;
        cyc(6);
        `CHK(tx_data_allow, 4'h0)
        rd32(BRC_OFS_GLB_EN, 32'h1);
        rd32(BRC_OFS_GLB_STAT, 32'h3ff);
        rd32(BRC_OFS_SERDES_GLB, 32'h0);
        wr32(12'h300, 32'hffffffff);
        rd32(12'h300, 32'h0);
        seed = lfsr(seed);
        wr32(BRC_OFS_SCRATCH, {16'h0, seed});
        rd32(BRC_OFS_SCRATCH, {16'h0, seed});
        $display("test registers done");
        for (int b = 1; b < BRC_NUM_BLK; b++) begin
            wr32(BRC_OFS_BLK_BASE + 12'(8 * b), 32'h0);
            cyc(4);
            `CHK(blk_rst, 9'(1 << b))
            `CHK(common_rst, 1'b0)
            clk_chk(10'h3ff & ~(10'h1 << b));
            rd32(BRC_OFS_GLB_STAT, 32'h3ff & ~(32'h1 << (b + 1)));
            rd32(BRC_OFS_SCRATCH, {16'h0, seed});
            wr32(BRC_OFS_BLK_BASE + 12'(8 * b), 32'h1);
            cyc(6);
            `CHK(blk_rst, 9'h000)
        end
        $display("test blocks done");
        wr32(BRC_OFS_BLK_BASE, 32'h0);
        cyc(4);
        `CHK(blk_rst, 9'h001)
        clk_chk(10'h3ff);
        rd32(BRC_OFS_SCRATCH, 32'h0);
        rd32(BRC_OFS_GLB_STAT, 32'h3fd);
        wr32(BRC_OFS_BLK_BASE, 32'h1);
        cyc(6);
        wr32(BRC_OFS_SCRATCH, {16'h0, seed});
        $display("test register block done");
        wr32(BRC_OFS_GLB_EN, 32'h0);
        cyc(4);
        `CHK(common_rst, 1'b1)
        `CHK(blk_rst, 9'h1ff)
        `CHK(serdes_rst, 1'b0)
        clk_chk(10'h001);
        rd32(BRC_OFS_GLB_EN, 32'h0);
        rd32(BRC_OFS_GLB_STAT, 32'h0);
        rd32(BRC_OFS_SCRATCH, 32'h0);
        wr32(BRC_OFS_GLB_EN, 32'h1);
        cyc(6);
        rd32(BRC_OFS_GLB_STAT, 32'h3ff);
        $display("test global done");
        seed = lfsr(seed);
        wr32(BRC_OFS_SERDES_GLB, 32'h1);
        wr32(BRC_OFS_TX_CFG, 32'h1);
        wr32(BRC_OFS_RX_CFG + 12'h4, 32'h1);
        tx_serial <= seed[3:0];
        cyc(3);
        `CHK(serdes_pll_enable, 1'b1)
        `CHK(serdes_tx_enable, 4'h1)
        `CHK(serdes_rx_enable, 4'h2)
        `CHK(tx_positive_output, {3'h7, seed[0]})
        `CHK(tx_negative_output, {3'h7, ~seed[0]})
        $display("test serdes done");
        link_init_done <= 4'h0;
        cyc(8);
        `CHK(port_retrain, 4'h0)
        `CHK(tx_data_allow, 4'h0)
        link_init_done <= 4'hf;
        cyc(8);
        `CHK(tx_data_allow, 4'hf)
        wr32(BRC_OFS_BLK_BASE + 12'h28, 32'h0);
        cyc(4);
        `CHK(port_retrain[0], 1'b1)
        `CHK(tx_data_allow[0], 1'b0)
        $display("test link done");
        // pll goes down only as the last step, a full shutdown
        wr32(BRC_OFS_SERDES_GLB, 32'h0);
        cyc(3);
        `CHK(serdes_pll_enable, 1'b0)
        `CHK(serdes_tx_enable, 4'h0)
        `CHK(serdes_rx_enable, 4'h0)
        `CHK(tx_positive_output & tx_negative_output, 4'hf)
        $display("test shutdown done");
        cyc(4);
        close_out();
    end
endmodule
